// >>> common/uart_rx_cfg.svh
// Register map, field positions, reset values and timing counts of the receive/data block.
// Assumes a 12-bit byte address on the register bus.
`ifndef UART_RX_CFG_SVH
`define UART_RX_CFG_SVH
// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define OFS_DATA_PORT     12'h000
`define OFS_ERR_STATUS    12'h004
`define OFS_LINE_CONTROL  12'h01c
`define OFS_BAUD_DIVISOR  12'h024
`define OFS_IRQ_ENABLE    12'h038
`define OFS_IRQ_STATUS    12'h03c
`define OFS_IRQ_CLEAR     12'h044
// ---------------------------------------------------------------
// Fields
// ---------------------------------------------------------------
`define DP_FRAMING_BIT    8
`define DP_OVERRUN_BIT    11
`define LC_PARITY_EN_BIT  1
`define LC_EVEN_BIT       2
`define LC_FIFO_EN_BIT    4
`define LC_STICK_BIT      7
`define IRQ_WIDTH         5
`define IRQ_CHAR_BIT      0
`define IRQ_OVERRUN_BIT   4
// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define LINE_CONTROL_RST  8'h00
`define BAUD_DIVISOR_RST  16'h0000
`define IRQ_ENABLE_RST    5'h00
`define START_MID_TICK    4'h7
`define LAST_TICK         4'hf
`define LAST_DATA_BIT     3'h7
`define RESP_OKAY         2'h0
`define RESP_DECERR       2'h3
`endif

// >>> common/uart_rx_pkg.sv
// Types shared by the receive/data block.
// Assumes nothing of its surroundings.
package uart_rx_pkg;
   typedef enum logic [5:0] {
      RX_IDLE     = 6'b000001,
      RX_START    = 6'b000010,
      RX_DATA     = 6'b000100,
      RX_PARITY   = 6'b001000,
      RX_STOP     = 6'b010000,
      RX_WAITHIGH = 6'b100000
   } rx_state_t;
   typedef enum logic [3:0] {
      RD_IDLE = 4'b0001,
      RD_POP  = 4'b0010,
      RD_FORM = 4'b0100,
      RD_RESP = 4'b1000
   } rd_state_t;
endpackage

// >>> src/rx_fifo_mem.sv
// Storage array of the receive FIFO, one write port and a registered read port.
// Assumes the caller keeps the pointers; the array itself has no reset.
`timescale 1ns/10ps
module rx_fifo_mem #(
   parameter int WIDTH  = 11,
   parameter int DEPTH  = 16,
   parameter int ADDR_W = 4
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              arst_n,
   // Write port
   input  wire logic              wrEn,
   input  wire logic [ADDR_W-1:0] wrAddr,
   input  wire logic [WIDTH-1:0]  wrData,
   // Read port
   input  wire logic [ADDR_W-1:0] rdAddr,
   output logic      [WIDTH-1:0]  rdData
);
   logic [WIDTH-1:0] store [DEPTH];

   always_ff @(posedge clock) begin
      if (wrEn) begin
         store[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= '0;
      end else begin
         rdData <= store[rdAddr];
      end
   end
endmodule

// >>> src/rx_serial_frame.sv
// Receive deserialiser: one start bit, eight data bits, optional parity, one stop bit.
// Assumes tickEn pulses sixteen times per bit period.
`timescale 1ns/10ps
`include "uart_rx_cfg.svh"
module rx_serial_frame import uart_rx_pkg::*; (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // Control
   input  wire logic       tickEn,
   input  wire logic       parityEnable,
   input  wire logic       evenParity,
   input  wire logic       stickParity,
   // Serial line
   input  wire logic       rxPin,
   // Received character
   output logic            charValid,
   output logic [7:0]      charData,
   output logic            framingErr,
   output logic            parityErr,
   output logic            breakErr
);
   logic [2:0] sync_reg, sync_next;
   logic       line_reg, line_next;
   rx_state_t  state_reg, state_next;
   logic [3:0] tick_reg, tick_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] shift_reg, shift_next;
   logic       par_reg, par_next;
   logic       valid_next, frm_next, perr_next, brk_next;
   logic [7:0] data_next;
   logic       expected;

   always_comb begin
      sync_next  = {sync_reg[1:0], rxPin};
      line_next  = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : line_reg;
      state_next = state_reg;
      tick_next  = tick_reg;
      bit_next   = bit_reg;
      shift_next = shift_reg;
      par_next   = par_reg;
      valid_next = 1'b0;
      data_next  = charData;
      frm_next   = framingErr;
      perr_next  = parityErr;
      brk_next   = breakErr;
      expected   = stickParity ? !evenParity : (evenParity ? ^shift_reg : ~^shift_reg);
      unique case (state_reg)
         RX_IDLE: begin
            tick_next = '0;
            if (!line_reg) begin
               state_next = RX_START;
            end
         end
         RX_START: if (tickEn) begin
            tick_next = tick_reg + 4'h1;
            if (tick_reg == `START_MID_TICK) begin
               tick_next  = '0;
               bit_next   = '0;
               state_next = line_reg ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA, RX_PARITY, RX_STOP: if (tickEn) begin
            tick_next = tick_reg + 4'h1;
            if (tick_reg == `LAST_TICK) begin
               if (state_reg == RX_DATA) begin
                  shift_next = {line_reg, shift_reg[7:1]};
                  bit_next   = bit_reg + 3'h1;
                  if (bit_reg == `LAST_DATA_BIT) begin
                     state_next = parityEnable ? RX_PARITY : RX_STOP;
                  end
               end else if (state_reg == RX_PARITY) begin
                  par_next   = line_reg;
                  state_next = RX_STOP;
               end else begin
                  valid_next = 1'b1;
                  // All-zero frame with a low stop bit is a break
                  brk_next   = !line_reg && shift_reg == 8'h00 && !(parityEnable && par_reg);
                  frm_next   = !line_reg && !brk_next;
                  perr_next  = parityEnable && !brk_next && par_reg != expected;
                  data_next  = brk_next ? 8'h00 : shift_reg;
                  par_next   = 1'b0;
                  // A stop bit still low must not be taken as the next start bit
                  state_next = line_reg ? RX_IDLE : RX_WAITHIGH;
               end
            end
         end
         RX_WAITHIGH: if (line_reg) begin
            state_next = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sync_reg   <= 3'h7;
         line_reg   <= 1'b1;
         state_reg  <= RX_IDLE;
         tick_reg   <= '0;
         bit_reg    <= '0;
         shift_reg  <= '0;
         par_reg    <= 1'b0;
         charValid  <= 1'b0;
         charData   <= '0;
         framingErr <= 1'b0;
         parityErr  <= 1'b0;
         breakErr   <= 1'b0;
      end else begin
         sync_reg   <= sync_next;
         line_reg   <= line_next;
         state_reg  <= state_next;
         tick_reg   <= tick_next;
         bit_reg    <= bit_next;
         shift_reg  <= shift_next;
         par_reg    <= par_next;
         charValid  <= valid_next;
         charData   <= data_next;
         framingErr <= frm_next;
         parityErr  <= perr_next;
         breakErr   <= brk_next;
      end
   end
endmodule

// >>> src/uart_rx_data_error_status.sv
// Data port, receive FIFO and receive error status of an asynchronous serial port.
// Assumes an AXI4-Lite master on one side and a serial transmitter on rxPin.
// What this block does
// - Data port write with byte 0 strobe set sends low byte to transmit path unless txFull, else it is dropped; read returns oldest received byte.
// - Framing flag, data bit 8 and status bit 0, set when stop bit is low and the frame is not a break.
// - Parity flag, data bit 9 and status bit 1, set on parity mismatch per control.
// - Break flag, data bit 10 and status bit 2, set when line low a frame.
// - Break stores one zero character, then waits for line high and new start.
// - Overrun flag, data bit 11 and status bit 3, set when a character arrives while full; FIFO untouched.
// - Data port overrun flag clears itself once the FIFO has room again.
// - Any write to error clear register clears all four sticky status flags.
// - In FIFO mode data port flags describe the character at the FIFO top.
// - Error clear is write-only at offset 0x04, shared with the status register.
`timescale 1ns/10ps
`include "uart_rx_cfg.svh"
module uart_rx_data_error_status import uart_rx_pkg::*; #(
   parameter int DEPTH  = 16,
   parameter int PTR_W  = 4,
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              arst_n,
   // AXI4-Lite write address
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   // AXI4-Lite write response
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   output logic [1:0]             s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   // AXI4-Lite read data
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   // Serial receive line
   input  wire logic              rxPin,
   // Transmit path
   output logic                   txPush,
   output logic [7:0]             txData,
   input  wire logic              txFull,
   // Interrupt
   output logic                   irq
);
   localparam int EW = 11;

   // ---------------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------------
   logic              awHave_reg, awHave_next, wHave_reg, wHave_next;
   logic [ADDR_W-1:0] awAddr_reg, awAddr_next;
   logic [31:0]       wData_reg, wData_next;
   logic [3:0]        wStrb_reg, wStrb_next;
   logic              bValid_reg, bValid_next;
   logic [1:0]        bResp_reg, bResp_next;
   logic              doWrite, wrData, wrClear, wrLine, wrDiv, wrIrqEn, wrIrqClr;
   logic              txPush_next;
   logic [7:0]        txData_next;

   assign s_axi_awready = !awHave_reg && !bValid_reg;
   assign s_axi_wready  = !wHave_reg && !bValid_reg;
   assign s_axi_bvalid  = bValid_reg;
   assign s_axi_bresp   = bResp_reg;
   assign doWrite       = awHave_reg && wHave_reg && !bValid_reg;

   always_comb begin
      awHave_next = awHave_reg;
      wHave_next  = wHave_reg;
      awAddr_next = awAddr_reg;
      wData_next  = wData_reg;
      wStrb_next  = wStrb_reg;
      bValid_next = bValid_reg;
      bResp_next  = bResp_reg;
      wrData = 1'b0;
      wrClear = 1'b0;
      wrLine = 1'b0;
      wrDiv = 1'b0;
      wrIrqEn = 1'b0;
      wrIrqClr = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         awHave_next = 1'b1;
         awAddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHave_next = 1'b1;
         wData_next = s_axi_wdata;
         wStrb_next = s_axi_wstrb;
      end
      if (doWrite) begin
         awHave_next = 1'b0;
         wHave_next  = 1'b0;
         bValid_next = 1'b1;
         bResp_next  = `RESP_OKAY;
         unique case ({awAddr_reg[ADDR_W-1:2], 2'b00})
            `OFS_DATA_PORT:    wrData   = 1'b1;
            `OFS_ERR_STATUS:   wrClear  = 1'b1;
            `OFS_LINE_CONTROL: wrLine   = 1'b1;
            `OFS_BAUD_DIVISOR: wrDiv    = 1'b1;
            `OFS_IRQ_ENABLE:   wrIrqEn  = 1'b1;
            `OFS_IRQ_CLEAR:    wrIrqClr = 1'b1;
            default:           bResp_next = `RESP_DECERR;
         endcase
      end else if (bValid_reg && s_axi_bready) begin
         bValid_next = 1'b0;
      end
      txPush_next = wrData && wStrb_reg[0] && !txFull;
      txData_next = txPush_next ? wData_reg[7:0] : txData;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         awHave_reg <= 1'b0;
         wHave_reg  <= 1'b0;
         awAddr_reg <= '0;
         wData_reg  <= '0;
         wStrb_reg  <= '0;
         bValid_reg <= 1'b0;
         bResp_reg  <= `RESP_OKAY;
         txPush     <= 1'b0;
         txData     <= '0;
      end else begin
         awHave_reg <= awHave_next;
         wHave_reg  <= wHave_next;
         awAddr_reg <= awAddr_next;
         wData_reg  <= wData_next;
         wStrb_reg  <= wStrb_next;
         bValid_reg <= bValid_next;
         bResp_reg  <= bResp_next;
         txPush     <= txPush_next;
         txData     <= txData_next;
      end
   end

   // ---------------------------------------------------------------
   // Configuration and bit-rate divider
   // ---------------------------------------------------------------
   logic [7:0]            lineCtl_reg, lineCtl_next;
   logic [15:0]           divisor_reg, divisor_next, divCnt_reg, divCnt_next;
   logic [`IRQ_WIDTH-1:0] irqEn_reg, irqEn_next;
   logic                  tickEn, fifoEn;

   assign tickEn = divisor_reg != 16'h0000 && divCnt_reg == divisor_reg - 16'h0001;
   assign fifoEn = lineCtl_reg[`LC_FIFO_EN_BIT];

   always_comb begin
      lineCtl_next = wrLine ? wData_reg[7:0] : lineCtl_reg;
      divisor_next = wrDiv ? wData_reg[15:0] : divisor_reg;
      irqEn_next   = wrIrqEn ? wData_reg[`IRQ_WIDTH-1:0] : irqEn_reg;
      divCnt_next  = (tickEn || wrDiv) ? 16'h0000 : divCnt_reg + 16'h0001;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lineCtl_reg <= `LINE_CONTROL_RST;
         divisor_reg <= `BAUD_DIVISOR_RST;
         irqEn_reg   <= `IRQ_ENABLE_RST;
         divCnt_reg  <= '0;
      end else begin
         lineCtl_reg <= lineCtl_next;
         divisor_reg <= divisor_next;
         irqEn_reg   <= irqEn_next;
         divCnt_reg  <= divCnt_next;
      end
   end

   // ---------------------------------------------------------------
   // Receiver and FIFO
   // ---------------------------------------------------------------
   logic             charValid, charFrm, charPar, charBrk;
   logic [7:0]       charData;
   logic [PTR_W-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic [PTR_W:0]   count_reg, count_next;
   logic             full, push, pop, overrun;
   logic [EW-1:0]    topEntry;

   rx_serial_frame receiver (
      .clock        (clock),
      .arst_n       (arst_n),
      .tickEn       (tickEn),
      .parityEnable (lineCtl_reg[`LC_PARITY_EN_BIT]),
      .evenParity   (lineCtl_reg[`LC_EVEN_BIT]),
      .stickParity  (lineCtl_reg[`LC_STICK_BIT]),
      .rxPin        (rxPin),
      .charValid    (charValid),
      .charData     (charData),
      .framingErr   (charFrm),
      .parityErr    (charPar),
      .breakErr     (charBrk)
   );

   rx_fifo_mem #(.WIDTH(EW), .DEPTH(DEPTH), .ADDR_W(PTR_W)) storage (
      .clock  (clock),
      .arst_n (arst_n),
      .wrEn   (push),
      .wrAddr (wrPtr_reg),
      .wrData ({charBrk, charPar, charFrm, charData}),
      .rdAddr (rdPtr_reg),
      .rdData (topEntry)
   );

   // With the FIFO off the queue is a single holding entry
   assign full    = fifoEn ? count_reg == (PTR_W+1)'(DEPTH) : count_reg != '0;
   assign push    = charValid && !full;
   assign overrun = charValid && full;

   always_comb begin
      wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
      count_next = count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         count_reg <= count_next;
      end
   end

   // ---------------------------------------------------------------
   // Error flags and interrupts
   // ---------------------------------------------------------------
   logic                  ovrLive_reg, ovrLive_next;
   logic [3:0]            sticky_reg, sticky_next, errSet;
   logic [`IRQ_WIDTH-1:0] irqStat_reg, irqStat_next, irqSet;

   assign errSet = {overrun, push && charBrk, push && charPar, push && charFrm};
   assign irqSet = {errSet, push};
   assign irq    = |(irqStat_reg & irqEn_reg);

   always_comb begin
      // Set wins over any clear arriving in the same cycle
      ovrLive_next = overrun || (ovrLive_reg && full);
      sticky_next  = errSet | (wrClear ? 4'h0 : sticky_reg);
      irqStat_next = irqSet | (irqStat_reg & ~(wrIrqClr ? wData_reg[`IRQ_WIDTH-1:0] : '0));
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ovrLive_reg <= 1'b0;
         sticky_reg  <= '0;
         irqStat_reg <= '0;
      end else begin
         ovrLive_reg <= ovrLive_next;
         sticky_reg  <= sticky_next;
         irqStat_reg <= irqStat_next;
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   rd_state_t         rdState_reg, rdState_next;
   logic [ADDR_W-1:0] arAddr_reg, arAddr_next;
   logic              hadChar_reg, hadChar_next, ovrSnap_reg, ovrSnap_next;
   logic [31:0]       rData_reg, rData_next;
   logic [1:0]        rResp_reg, rResp_next;
   logic              rdIsData;

   assign s_axi_arready = rdState_reg == RD_IDLE;
   assign s_axi_rvalid  = rdState_reg == RD_RESP;
   assign s_axi_rdata   = rData_reg;
   assign s_axi_rresp   = rResp_reg;
   assign rdIsData      = {arAddr_reg[ADDR_W-1:2], 2'b00} == `OFS_DATA_PORT;
   assign pop           = rdState_reg == RD_POP && rdIsData && count_reg != '0;

   always_comb begin
      rdState_next = rdState_reg;
      arAddr_next  = arAddr_reg;
      hadChar_next = hadChar_reg;
      ovrSnap_next = ovrSnap_reg;
      rData_next   = rData_reg;
      rResp_next   = rResp_reg;
      unique case (rdState_reg)
         RD_IDLE: if (s_axi_arvalid) begin
            arAddr_next  = s_axi_araddr;
            rdState_next = RD_POP;
         end
         RD_POP: begin
            hadChar_next = count_reg != '0;
            ovrSnap_next = ovrLive_reg;
            rdState_next = RD_FORM;
         end
         RD_FORM: begin
            rResp_next   = `RESP_OKAY;
            rData_next   = 32'h0000_0000;
            rdState_next = RD_RESP;
            unique case ({arAddr_reg[ADDR_W-1:2], 2'b00})
               `OFS_DATA_PORT: begin
                  // Flags travel with the character just popped from the top
                  if (hadChar_reg) begin
                     rData_next[`DP_OVERRUN_BIT-1:0] = topEntry;
                  end
                  rData_next[`DP_OVERRUN_BIT] = ovrSnap_reg;
               end
               `OFS_ERR_STATUS:   rData_next[3:0] = sticky_reg;
               `OFS_LINE_CONTROL: rData_next[7:0] = lineCtl_reg;
               `OFS_BAUD_DIVISOR: rData_next[15:0] = divisor_reg;
               `OFS_IRQ_ENABLE:   rData_next[`IRQ_WIDTH-1:0] = irqEn_reg;
               `OFS_IRQ_STATUS:   rData_next[`IRQ_WIDTH-1:0] = irqStat_reg;
               `OFS_IRQ_CLEAR:    rData_next = 32'h0000_0000;
               default:           rResp_next = `RESP_DECERR;
            endcase
         end
         RD_RESP: if (s_axi_rready) begin
            rdState_next = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdState_reg <= RD_IDLE;
         arAddr_reg  <= '0;
         hadChar_reg <= 1'b0;
         ovrSnap_reg <= 1'b0;
         rData_reg   <= '0;
         rResp_reg   <= `RESP_OKAY;
      end else begin
         rdState_reg <= rdState_next;
         arAddr_reg  <= arAddr_next;
         hadChar_reg <= hadChar_next;
         ovrSnap_reg <= ovrSnap_next;
         rData_reg   <= rData_next;
         rResp_reg   <= rResp_next;
      end
   end
endmodule

// >>> testbench/uart_rx_data_error_status_asserts.sv
// Port checker of the receive/data block.
// Assumes it is bound to the block top and sees only its ports.
`timescale 1ns/10ps
module uart_rx_data_error_status_asserts #(parameter int ADDR_W = 12) (
   // Clock, reset and side pins
   input wire logic              clock, arst_n, txPush, txFull, irq,
   // Register bus handshakes
   input wire logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   // Register bus payloads
   input wire logic [1:0]        s_axi_bresp, s_axi_rresp,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [31:0]       s_axi_rdata
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire arTake = s_axi_arvalid && s_axi_arready;
   wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

   a_push_pulse: assert property (txPush |=> !txPush) else $error("push too long");
   a_push_cause: assert property (txPush |-> ##[0:1] s_axi_bvalid) else $error("push without write");
   a_full_drop: assert property (txFull [*3] |-> !txPush) else $error("push while full");
   a_write_resp: assert property (wrTake |-> ##2 s_axi_bvalid) else $error("late write answer");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_read_lat: assert property (arTake |-> ##3 s_axi_rvalid) else $error("late read answer");
   a_resv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:12] == 20'h0) else $error("upper bits set");
   a_status_width: assert property (arTake && s_axi_araddr == 12'h004 |-> ##3 s_axi_rdata[31:4] == 28'h0)
      else $error("status upper bits set");
   a_unmapped_read: assert property (arTake && s_axi_araddr == 12'h008 |-> ##3 s_axi_rdata == 32'h0
      && s_axi_rresp == 2'h3) else $error("unmapped read answer");

   c_push: cover property (txPush);
   c_overrun: cover property (s_axi_rvalid && s_axi_rdata[11]);
   c_irq: cover property (irq);
endmodule

bind uart_rx_data_error_status uart_rx_data_error_status_asserts #(.ADDR_W(ADDR_W)) chk (
   .clock, .arst_n, .txPush, .txFull, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bresp, .s_axi_rresp,
   .s_axi_araddr, .s_axi_rdata);

// >>> testbench/serial_tx_model.sv
// Remote serial transmitter on the receive line.
// Assumes BIT_NS equals the programmed bit period.
`timescale 1ns/10ps
module serial_tx_model #(parameter int BIT_NS = 320) (
   // Serial line, idle high
   output logic rxPin
);
   initial rxPin = 1'h1;
   // Start, data LSB first, optional parity, stop, one idle bit
   task automatic send(input logic [7:0] d, input logic usePar, parBit, stopBit);
      rxPin = 1'h0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++) begin
         rxPin = d[i];
         #(BIT_NS);
      end
      if (usePar) begin
         rxPin = parBit;
         #(BIT_NS);
      end
      rxPin = stopBit;
      #(BIT_NS);
      rxPin = 1'h1;
      #(BIT_NS);
   endtask
   task automatic hold_low(input int n);
      rxPin = 1'h0;
      #(BIT_NS * n);
      rxPin = 1'h1;
      #(BIT_NS * 2);
   endtask
endmodule

// >>> testbench/test_uart_rx_data_error_status.sv
// Self-checking bench of the receive/data block.
// Assumes the serial model beside it and the bound port checker.
`timescale 1ns/10ps
module test_uart_rx_data_error_status;
   logic clock = 1'h0, arst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
   logic rready = 1'h1, txFull = 1'h0, awready, wready, bvalid, arready, rvalid, txPush, irq, rxPin;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   logic [7:0]  txData;
   int          err_count = 0, samples_checked = 0, cycles = 0;

   uart_rx_data_error_status #(.DEPTH(4), .PTR_W(2)) dut (
      .clock, .arst_n, .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .rxPin, .txPush, .txData, .txFull, .irq);
   serial_tx_model tx (.rxPin);

   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clock);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      chk(bresp, er);
      bready <= 1'h0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'h0;
      do @(posedge clock); while (!rvalid);
      chk(rdata, exp);
      chk(rresp, er);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clock);
      arst_n <= 1'h1;
      @(posedge clock);
      wr(12'h024, 32'h2, 2'h0);
      wr(12'h01c, 32'h12, 2'h0);
      wr(12'h000, 32'h1a5, 2'h0);
      chk(txData, 8'ha5);
      txFull <= 1'h1;
      wr(12'h000, 32'h33, 2'h0);
      txFull <= 1'h0;
      chk(txData, 8'ha5);
      wr(12'h03c, 32'h1, 2'h3);
      rd(12'h008, 32'h0, 2'h3);
      $display("done tx");
      tx.send(8'h3c, 1'h1, ~^8'h3c, 1'h1);
      tx.send(8'h55, 1'h1, ^8'h55, 1'h1);
      tx.send(8'h81, 1'h1, ~^8'h81, 1'h0);
      @(posedge clock);
      rd(12'h004, 32'h3, 2'h0);
      rd(12'h000, 32'h03c, 2'h0);
      rd(12'h000, 32'h255, 2'h0);
      rd(12'h000, 32'h181, 2'h0);
      rd(12'h000, 32'h0, 2'h0);
      wr(12'h004, 32'hffff0000, 2'h0);
      rd(12'h004, 32'h0, 2'h0);
      $display("done errors");
      wr(12'h01c, 32'h10, 2'h0);
      tx.hold_low(22);
      tx.send(8'h66, 1'h0, 1'h0, 1'h1);
      @(posedge clock);
      rd(12'h004, 32'h4, 2'h0);
      rd(12'h000, 32'h400, 2'h0);
      rd(12'h000, 32'h066, 2'h0);
      rd(12'h000, 32'h0, 2'h0);
      wr(12'h004, 32'h0, 2'h0);
      $display("done break");
      for (int i = 1; i < 6; i++) tx.send(8'(i), 1'h0, 1'h0, 1'h1);
      @(posedge clock);
      rd(12'h004, 32'h8, 2'h0);
      rd(12'h000, 32'h801, 2'h0);
      rd(12'h000, 32'h002, 2'h0);
      rd(12'h000, 32'h003, 2'h0);
      rd(12'h000, 32'h004, 2'h0);
      rd(12'h000, 32'h0, 2'h0);
      tx.send(8'h77, 1'h0, 1'h0, 1'h1);
      @(posedge clock);
      rd(12'h000, 32'h077, 2'h0);
      $display("done overrun");
      wr(12'h038, 32'h1, 2'h0);
      chk(irq, 1'h1);
      wr(12'h038, 32'h0, 2'h0);
      chk(irq, 1'h0);
      wr(12'h038, 32'h1, 2'h0);
      wr(12'h044, 32'h1f, 2'h0);
      chk(irq, 1'h0);
      $display("done irq");
      tally_and_finish();
   end
endmodule
